// *** src/kgr_regs.sv ***
// keypad port output, autorepeat and autosleep configuration registers
// Function
// R1 - port bits 7..2 pull their pin low when 0 and release it when 1.
// R2 - port bit 1 pulls the key interrupt pin low when 0 and releases it when 1.
// R3 - the port register resets to ones in bits 7..1 and zero in reserved bit 0.
// R4 - repeat bit 7 clear disables autorepeat; set, delay is (d3:d0+1)*8 debounce cycles.
// R5 - repeat interval is (d6:d4+1)*4 debounce cycles.
// R6 - the autorepeat register resets to zero.
// R7 - sleep code 0 is off, 1..5 give 8192..512 ms, 6 and 7 give 256 ms; reset is 7.
// R8 - one debounce cycle lasts the programmed debounce time, 9 to 40 ms.
// R9 - a column follows its port bit only while the port-enable field makes it an output.
// R10 - a held key repeats once after the delay, then every interval until release.
`timescale 1ns/1ps
`include "kgr_defines.svh"
module kgr_regs
    import kgr_pkg::*;
#(
    parameter int MS_CYCLES = `KGR_MS_CYCLES
) (
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    input  wire logic       wr_en_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       key_held_in,
    input  wire logic       key_key_event_irq_pin_gpo_in,
    input  wire logic       activity_in,
    output logic      [7:0] rdata_out,
    output logic      [7:2] spare_column_output_oe_out,
    output logic      [7:2] spare_column_output_gpo_out,
    output logic            key_event_irq_pin_oe_out,
    output logic            repeat_event_out,
    output logic            sleep_req_out
);
    logic [7:0] ports_r, ports_nxt, rpt_r, rpt_nxt, slp_r, slp_nxt, deb_r, deb_nxt;
    logic [7:0] rdata_nxt;
    logic [7:2] oe_r, oe_nxt, gpo_r, gpo_nxt;
    logic       irq_oe_r, irq_oe_nxt;
    logic [31:0] ms_cnt_r, ms_cnt_nxt;
    logic [5:0]  deb_ms_r, deb_ms_nxt;
    logic        tick;
    logic        ms_tick;
    kgr_state_t  st_r, st_nxt;
    logic [7:0]  dc_r, dc_nxt;
    logic        rpt_ev_r, rpt_ev_nxt;
    logic [13:0] slp_ms_r, slp_ms_nxt;
    logic [13:0] slp_lim;
    logic        slp_r_out, slp_out_nxt;
    logic [7:0]  delay_cyc, rate_cyc;

    always_comb begin
        ports_nxt = ports_r;
        rpt_nxt   = rpt_r;
        slp_nxt   = slp_r;
        deb_nxt   = deb_r;
        if (wr_en_in) begin
            case (addr_in)
                `KGR_ADDR_PORTS:    ports_nxt = {wdata_in[7:1], 1'b0}; // [R3]
                `KGR_ADDR_REPEAT:   rpt_nxt   = wdata_in;
                `KGR_ADDR_SLEEP:    slp_nxt   = {5'h00, wdata_in[2:0]};
                `KGR_ADDR_DEBOUNCE: deb_nxt   = wdata_in;
                default:            ;
            endcase
        end
        case (addr_in)
            `KGR_ADDR_PORTS:    rdata_nxt = ports_r;
            `KGR_ADDR_REPEAT:   rdata_nxt = rpt_r;
            `KGR_ADDR_SLEEP:    rdata_nxt = slp_r;
            `KGR_ADDR_DEBOUNCE: rdata_nxt = deb_r;
            default:            rdata_nxt = 8'h00;
        endcase
    end

    // column output enable from the port-enable field
    always_comb begin
        logic [2:0] n;
        n = 3'h0;
        case (deb_r[7:5])
            3'h0:    n = 3'h0;
            3'h1:    n = 3'h1;
            3'h2:    n = 3'h2;
            3'h3:    n = 3'h3;
            3'h4:    n = 3'h4;
            3'h5:    n = 3'h5;
            default: n = 3'h6;
        endcase
        for (int i = 2; i <= 7; i++) begin
            gpo_nxt[i] = (3'(8 - i) <= n);                  // [R9]
            oe_nxt[i]  = gpo_nxt[i] && !ports_nxt[i];       // [R1]
        end
        irq_oe_nxt = key_key_event_irq_pin_gpo_in && !ports_nxt[1];      // [R2]
    end

    // debounce-cycle timebase
    assign ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1));
    assign tick    = ms_tick && (deb_ms_r >= 6'(`KGR_DEB_MIN_MS - 1) + {1'b0, deb_r[4:0]}); // [R8]
    always_comb begin
        ms_cnt_nxt = ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
        deb_ms_nxt = deb_ms_r;
        if (ms_tick) begin
            deb_ms_nxt = tick ? 6'h00 : deb_ms_r + 6'h01;
        end
    end

    // autorepeat engine
    assign delay_cyc = 8'((rpt_r[3:0] + 5'h01) * `KGR_DELAY_STEP); // [R4]
    assign rate_cyc  = 8'((rpt_r[6:4] + 4'h1) * `KGR_RATE_STEP);   // [R5]
    always_comb begin
        st_nxt     = st_r;
        dc_nxt     = dc_r;
        rpt_ev_nxt = 1'b0;
        case (st_r)
            KGR_IDLE: begin
                dc_nxt = 8'h00;
                if (key_held_in && rpt_r[`KGR_RPT_EN_BIT]) begin // [R4]
                    st_nxt = KGR_DELAY;
                end
            end
            KGR_DELAY, KGR_RPT: begin
                if (!key_held_in || !rpt_r[`KGR_RPT_EN_BIT]) begin
                    st_nxt = KGR_IDLE;
                end else if (tick) begin
                    if (dc_r + 8'h01 >= ((st_r == KGR_DELAY) ? delay_cyc : rate_cyc)) begin
                        rpt_ev_nxt = 1'b1;                         // [R10]
                        dc_nxt     = 8'h00;
                        st_nxt     = KGR_RPT;
                    end else begin
                        dc_nxt = dc_r + 8'h01;
                    end
                end
            end
            default: st_nxt = KGR_IDLE;
        endcase
    end

    // autosleep timeout
    always_comb begin
        case (slp_r[2:0])                                           // [R7]
            3'h1:    slp_lim = 14'(`KGR_SLEEP_MS_MAX);
            3'h2:    slp_lim = 14'(`KGR_SLEEP_MS_MAX / 2);
            3'h3:    slp_lim = 14'(`KGR_SLEEP_MS_MAX / 4);
            3'h4:    slp_lim = 14'(`KGR_SLEEP_MS_MAX / 8);
            3'h5:    slp_lim = 14'(`KGR_SLEEP_MS_MAX / 16);
            3'h0:    slp_lim = 14'h0000;
            default: slp_lim = 14'(`KGR_SLEEP_MS_MAX / 32);
        endcase
        slp_ms_nxt  = slp_ms_r;
        slp_out_nxt = 1'b0;
        if (activity_in || slp_lim == 14'h0000) begin
            slp_ms_nxt = 14'h0000;
        end else if (slp_ms_r >= slp_lim) begin
            slp_out_nxt = 1'b1;
        end else if (ms_tick) begin
            slp_ms_nxt = slp_ms_r + 14'h0001;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            ports_r   <= `KGR_RST_PORTS;    // [R3]
            rpt_r     <= `KGR_RST_REPEAT;   // [R6]
            slp_r     <= `KGR_RST_SLEEP;    // [R7]
            deb_r     <= `KGR_RST_DEBOUNCE;
            rdata_out <= 8'h00;
            oe_r      <= 6'h00;
            gpo_r     <= 6'h00;
            irq_oe_r  <= 1'b0;
            ms_cnt_r  <= 32'h0;
            deb_ms_r  <= 6'h00;
            st_r      <= KGR_IDLE;
            dc_r      <= 8'h00;
            rpt_ev_r  <= 1'b0;
            slp_ms_r  <= 14'h0000;
            slp_r_out <= 1'b0;
        end else begin
            ports_r   <= ports_nxt;
            rpt_r     <= rpt_nxt;
            slp_r     <= slp_nxt;
            deb_r     <= deb_nxt;
            rdata_out <= rdata_nxt;
            oe_r      <= oe_nxt;
            gpo_r     <= gpo_nxt;
            irq_oe_r  <= irq_oe_nxt;
            ms_cnt_r  <= ms_cnt_nxt;
            deb_ms_r  <= deb_ms_nxt;
            st_r      <= st_nxt;
            dc_r      <= dc_nxt;
            rpt_ev_r  <= rpt_ev_nxt;
            slp_ms_r  <= slp_ms_nxt;
            slp_r_out <= slp_out_nxt;
        end
    end

    assign spare_column_output_oe_out  = oe_r;
    assign spare_column_output_gpo_out = gpo_r;
    assign key_event_irq_pin_oe_out    = irq_oe_r;
    assign repeat_event_out            = rpt_ev_r;
    assign sleep_req_out               = slp_r_out;

    a_port_pull_low: assert property (@(posedge mclk_in) disable iff (reset_in)
        wr_en_in && addr_in == `KGR_ADDR_PORTS && !wdata_in[7] && deb_r[7:5] != 3'h0
        |=> oe_r[7]) else $error("port 7 not pulled low"); // [R1]
    a_irq_release: assert property (@(posedge mclk_in) disable iff (reset_in)
        ports_r[1] |-> !irq_oe_r) else $error("irq pin driven while released"); // [R2]
    a_port_rsvd: assert property (@(posedge mclk_in) disable iff (reset_in)
        !ports_r[0]) else $error("reserved port bit set"); // [R3]
    a_rpt_disabled: assert property (@(posedge mclk_in) disable iff (reset_in)
        !rpt_r[7] |=> !repeat_event_out) else $error("repeat while disabled"); // [R4]
    a_rpt_single: assert property (@(posedge mclk_in) disable iff (reset_in)
        repeat_event_out |=> !repeat_event_out) else $error("repeat not a pulse"); // [R10]
    a_rpt_state: assert property (@(posedge mclk_in) disable iff (reset_in)
        repeat_event_out |-> st_r == KGR_RPT) else $error("repeat outside repeat state"); // [R5]
    a_rpt_release: assert property (@(posedge mclk_in) disable iff (reset_in)
        !key_held_in |=> st_r == KGR_IDLE) else $error("repeat survives release"); // [R10]
    a_col_scan: assert property (@(posedge mclk_in) disable iff (reset_in)
        deb_r[7:5] == 3'h0 |=> oe_r == 6'h00) else $error("scan column driven"); // [R9]
    a_sleep_off: assert property (@(posedge mclk_in) disable iff (reset_in)
        slp_r[2:0] == 3'h0 |=> !sleep_req_out) else $error("sleep while off"); // [R7]
    a_rpt_reset: assert property (@(posedge mclk_in) disable iff (reset_in)
        $fell(reset_in) |-> rpt_r == 8'h00) else $error("repeat reg not reset"); // [R6]
    a_tick_ms: assert property (@(posedge mclk_in) disable iff (reset_in)
        tick |-> ms_tick) else $error("debounce tick off ms grid"); // [R8]
    c_rpt_event: cover property (@(posedge mclk_in) repeat_event_out);
    c_sleep: cover property (@(posedge mclk_in) sleep_req_out);
    c_pull_low: cover property (@(posedge mclk_in) oe_r[2]);
endmodule : kgr_regs

// *** src/kgr_defines.svh ***
// register offsets, reset values and timing constants for the keypad config bank
`ifndef KGR_DEFINES_SVH
`define KGR_DEFINES_SVH
`define KGR_ADDR_PORTS      8'h04
`define KGR_ADDR_REPEAT     8'h05
`define KGR_ADDR_SLEEP      8'h06
`define KGR_ADDR_DEBOUNCE   8'h02
`define KGR_RST_PORTS       8'hFE
`define KGR_RST_REPEAT      8'h00
`define KGR_RST_SLEEP       8'h07
`define KGR_RST_DEBOUNCE    8'hFF
`define KGR_RPT_EN_BIT      7
`define KGR_DELAY_STEP      8
`define KGR_RATE_STEP       4
`define KGR_DEB_MIN_MS      9
`define KGR_MS_NS           1000000
`define KGR_CLK_NS          10
`define KGR_MS_CYCLES       (`KGR_MS_NS / `KGR_CLK_NS)
`define KGR_SLEEP_MS_MAX    8192
`endif

// *** src/kgr_pkg.sv ***
// types for the keypad config bank
package kgr_pkg;
    typedef enum logic [2:0] {
        KGR_IDLE  = 3'b001,
        KGR_DELAY = 3'b010,
        KGR_RPT   = 3'b100
    } kgr_state_t;
endpackage : kgr_pkg

// *** bench/kgr_host.sv ***
// host model issuing register writes and reads on the config port
`timescale 1ns/1ps
module kgr_host (
    input  wire logic       mclk_in,
    input  wire logic [7:0] rdata_in,
    output logic            wr_en_out,
    output logic      [7:0] addr_out,
    output logic      [7:0] wdata_out
);
    initial begin
        wr_en_out = 1'b0;
        addr_out  = 8'h00;
        wdata_out = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        wr_en_out = 1'b1;
        addr_out  = a;
        wdata_out = d;
        @(negedge mclk_in);
        wr_en_out = 1'b0;
        wdata_out = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk_in);
        addr_out = a;
        @(negedge mclk_in);
        d = rdata_in;
    endtask : rd
endmodule : kgr_host

// *** bench/tb.sv ***
// self-checking bench for the keypad config registers
`timescale 1ns/1ps
module tb;
    import kgr_pkg::*;
    localparam int MSC = 4;
    logic       mclk_in, reset_in, wr_en, key_held, key_event_irq_pin_gpo, activity, irq_oe, rpt, slp;
    logic [7:0] addr, wdata, rdata, v, deb, s, rd_v;
    logic [7:2] oe, spare_column_output, gexp;
    int         error_cnt, checks, n, tick, lim;
    longint     t0, t1, ts;
    kgr_regs #(.MS_CYCLES(MSC)) uut (.mclk_in(mclk_in), .reset_in(reset_in), .wr_en_in(wr_en),
        .addr_in(addr), .wdata_in(wdata), .key_held_in(key_held), .key_key_event_irq_pin_gpo_in(key_event_irq_pin_gpo),
        .activity_in(activity), .rdata_out(rdata), .spare_column_output_oe_out(oe),
        .spare_column_output_gpo_out(spare_column_output), .key_event_irq_pin_oe_out(irq_oe),
        .repeat_event_out(rpt), .sleep_req_out(slp));
    kgr_host host (.mclk_in(mclk_in), .rdata_in(rdata), .wr_en_out(wr_en), .addr_out(addr),
        .wdata_out(wdata));
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    function automatic logic [7:2] gpo_exp(input logic [7:0] d);
        int c = (d[7:6] == 2'b11) ? 6 : int'(d[7:5]);
        logic [7:2] r;
        for (int i = 2; i < 8; i++) r[i] = ((8 - i) <= c);
        return r;
    endfunction : gpo_exp
    function automatic int sleep_ms(input int c);
        return (c == 0) ? 0 : (c >= 6) ? 256 : (8192 >> (c - 1));
    endfunction : sleep_ms
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        if (error_cnt == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic hold_key(input int cyc);
        n = 0;
        @(negedge mclk_in);
        key_held = 1'b1;
        ts = $time;
        repeat (cyc) @(negedge mclk_in);
        key_held = 1'b0;
        repeat (5) @(negedge mclk_in);
    endtask : hold_key
    always @(posedge mclk_in) if (rpt === 1'b1) begin
        n++;
        t1 = $time;
        if (n == 1) t0 = $time;
    end
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    initial begin
        reset_in = 1'b1;
        {key_held, key_event_irq_pin_gpo, activity, error_cnt, checks, n, t0, t1} = '0;
        s = 8'h37;
        repeat (12) @(posedge mclk_in);
        @(negedge mclk_in) reset_in = 1'b0;
        check({2'b00, oe}, 8'h00);
        host.rd(8'h04, v); check(v, 8'hFE);
        host.rd(8'h05, v); check(v, 8'h00);
        host.rd(8'h06, v); check(v, 8'h07);
        host.rd(8'h10, v); check(v, 8'h00);
        // every column-enable code first, then random ones
        for (int k = 0; k < 24; k++) begin
            s = lfsr(s);
            v = s;
            s = lfsr(s);
            deb = (k < 8) ? {k[2:0], s[4:0]} : s;
            key_event_irq_pin_gpo = s[5];
            host.wr(8'h02, deb);
            host.wr(8'h04, v);
            host.rd(8'h04, rd_v); check(rd_v, v & 8'hFE);
            gexp = gpo_exp(deb);
            check({2'b00, spare_column_output}, {2'b00, gexp});
            check({2'b00, oe}, {2'b00, ~v[7:2] & gexp});
            check({7'h00, irq_oe}, {7'h00, ~v[1] & key_event_irq_pin_gpo});
        end
        host.wr(8'h06, 8'hFF); host.rd(8'h06, v); check(v, 8'h07);
        // every sleep code, 111 first and off last
        for (int c = 7; c >= 0; c--) begin
            lim = (c == 0) ? 2000 : sleep_ms(c) * MSC + 16;
            host.wr(8'h06, 8'(c));
            @(negedge mclk_in) activity = 1'b1;
            @(negedge mclk_in) activity = 1'b0;
            for (tick = 0; tick < lim && slp !== 1'b1; tick++) @(negedge mclk_in);
            if (c == 0) check(8'(tick == lim), 8'h01);
            else check(8'(tick > lim - 24 && tick < lim - 8), 8'h01);
            if (c != 0 && tick == lim) stop_test();
        end
        // debounce code 0 gives a 9 ms tick of 36 cycles
        host.wr(8'h02, 8'h00);
        host.wr(8'h05, 8'h91);
        hold_key(1300);
        check(8'(n), 8'h03);
        check(8'((t0 - ts) / 10 >= 540 && (t0 - ts) / 10 <= 620), 8'h01);
        check(8'((t1 - t0) / 10 / 36), 8'(2 * 8));
        host.wr(8'h05, 8'h70);
        hold_key(400);
        check(8'(n), 8'h00);
        stop_test();
    end
endmodule : tb
